/* File: src/iacq_event_qual.sv */
// Final qualification of one compare event: enable, space selector, address match.
// Assumes the instruction fields arrive together in one cycle.
`timescale 1ns/1ps
`default_nettype none
module iacq_event_qual (
  input wire logic valid,
  input wire logic enable,
  input wire logic [1:0] space_sel,
  input wire logic space_flag,
  input wire logic match,
  output logic hit
);

  // Only address and one space flag take part; no process id
  assign hit = valid & enable & match & iacq_pkg::space_ok(space_sel, space_flag);

endmodule : iacq_event_qual
`default_nettype wire

/* File: src/iacq_pair_cmp.sv */
// Address comparator for one pair of compare registers: exact or range.
// Assumes the mode and toggle state are stable registers in the caller.
`timescale 1ns/1ps
`default_nettype none
module iacq_pair_cmp #(
  parameter int unsigned AW = 32
) (
  input wire logic [AW-1:0] addr,
  input wire logic [AW-1:0] lo,
  input wire logic [AW-1:0] hi,
  input wire iacq_pkg::iacq_pair_cfg_t cfg,
  output logic match_lo,
  output logic match_hi
);

  if (AW < 2 || AW > 32) begin : g_bad_aw
    $error("iacq_pair_cmp: AW must lie in 2..32");
  end

  logic inclusive;
  logic in_range;
  logic range_hit;

  // Toggle status reverses the sense of both range codes, but only while the pair's toggle enable is set
  assign inclusive = (cfg.mode == iacq_pkg::IACQ_MODE_RINC) ^ (cfg.tgl_en & cfg.tgl_st);
  assign in_range = (lo <= addr) && (addr < hi);
  assign range_hit = inclusive ? in_range : ~in_range;

  // Mode select; reserved code yields no match
  always_comb begin
    case (cfg.mode)
      iacq_pkg::IACQ_MODE_EXACT: begin
        match_lo = (addr == lo);
        match_hi = (addr == hi);
      end
      iacq_pkg::IACQ_MODE_RINC, iacq_pkg::IACQ_MODE_REXC: begin
        match_lo = range_hit;
        match_hi = range_hit;
      end
      default: begin
        match_lo = 1'b0;
        match_hi = 1'b0;
      end
    endcase
  end

endmodule : iacq_pair_cmp
`default_nettype wire

/* File: src/iacq_pkg.sv */
// Shared constants, types and decode helpers for the instruction address compare qualifier.
// Assumes a 32-bit classic Wishbone register port and a 32-bit instruction address.
package iacq_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL0 = 8'h00;
  localparam logic [7:0] OFF_CTRL1 = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0C;
  localparam logic [7:0] OFF_CMP1 = 8'h10;
  localparam logic [7:0] OFF_CMP2 = 8'h14;
  localparam logic [7:0] OFF_CMP3 = 8'h18;
  localparam logic [7:0] OFF_CMP4 = 8'h1C;

  // Field positions
  localparam int unsigned CTL1_MODE_A_LSB = 0;
  localparam int unsigned CTL1_MODE_B_LSB = 2;
  localparam int unsigned CTL1_SPACE_LSB = 4;
  localparam int unsigned CTL1_TGL_A_BIT = 12;
  localparam int unsigned CTL1_TGL_B_BIT = 13;
  localparam int unsigned STAT_TS_LSB = 4;
  localparam int unsigned NUM_EVT = 4;
  localparam int unsigned NUM_PAIR = 2;

  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [3:0] RST_NIB = 4'h0;
  localparam logic [1:0] RST_PAIR = 2'h0;

  // Pair compare mode codes
  typedef enum logic [1:0] {
    IACQ_MODE_EXACT = 2'b00,
    IACQ_MODE_RSVD = 2'b01,
    IACQ_MODE_RINC = 2'b10,
    IACQ_MODE_REXC = 2'b11
  } iacq_mode_t;

  // Address space selector codes
  localparam logic [1:0] SPACE_ANY = 2'b00;
  localparam logic [1:0] SPACE_REAL = 2'b01;
  localparam logic [1:0] SPACE_ZERO = 2'b10;
  localparam logic [1:0] SPACE_ONE = 2'b11;

  // Instruction presented by the pipeline
  typedef struct packed {
    logic valid;
    logic space;
    logic [31:0] addr;
  } iacq_insn_t;

  // Per-pair configuration and toggle state
  typedef struct packed {
    iacq_mode_t mode;
    logic tgl_en;
    logic tgl_st;
  } iacq_pair_cfg_t;

  // Space selector check; reserved real-address code never matches
  function automatic logic space_ok(input logic [1:0] sel, input logic flag);
    case (sel)
      SPACE_ANY: space_ok = 1'b1;
      SPACE_ZERO: space_ok = ~flag;
      SPACE_ONE: space_ok = flag;
      default: space_ok = 1'b0;
    endcase
  endfunction : space_ok

endpackage : iacq_pkg

/* File: src/iacq_top.sv */
// Instruction address compare qualifier: four compare events, range auto-toggle,
// Wishbone register file and a level interrupt.
// Assumes one 50 MHz clock, a synchronous active-low reset and a pipeline that
// presents each attempted instruction for one cycle with its space flag.
//
// The Wishbone register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module iacq_top (
  input wire logic clock,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire iacq_pkg::iacq_insn_t insn,
  output logic [3:0] cmp_hit,
  output logic [1:0] pair_toggle_status,
  output logic irq
);

  localparam int unsigned AW = 32;

  // Bus handshake state
  logic ack_q;
  logic bus_req;
  logic bus_go;
  logic bus_done;
  logic wr_done;
  logic rd_done;

  // Register contents
  logic [3:0] evt_en_q;
  logic [31:0] ctrl1_q;
  logic [3:0] evt_st_q;
  logic [1:0] tgl_st_q;
  logic [3:0] mask_q;
  logic [31:0] cmp_q [iacq_pkg::NUM_EVT];
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic [3:0] hit_q;

  // Decoded configuration
  iacq_pkg::iacq_pair_cfg_t pair_cfg [iacq_pkg::NUM_PAIR];
  logic [1:0] space_sel [iacq_pkg::NUM_EVT];
  logic [3:0] match;
  logic [3:0] hit;
  logic [1:0] pair_evt;
  logic [1:0] tgl_en;

  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    merge = res;
  endfunction : merge

  // Address decode helper
  function automatic logic hit_off(input logic [7:0] adr, input logic [7:0] off);
    hit_off = (adr == off);
  endfunction : hit_off

  // Classic Wishbone: ack one cycle after the request, dropped after one cycle
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign bus_go = bus_req & ~ack_q;
  assign bus_done = bus_req & ack_q;
  assign wr_done = bus_done & wb_we_i;
  assign rd_done = bus_done & ~wb_we_i;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // Acknowledge register
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_go;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rdata_d = iacq_pkg::RST_WORD;
    case (wb_adr_i)
      iacq_pkg::OFF_CTRL0: rdata_d[3:0] = evt_en_q;
      iacq_pkg::OFF_CTRL1: rdata_d = ctrl1_q;
      iacq_pkg::OFF_STATUS: begin
        rdata_d[3:0] = evt_st_q;
        rdata_d[iacq_pkg::STAT_TS_LSB +: 2] = tgl_st_q;
      end
      iacq_pkg::OFF_MASK: rdata_d[3:0] = mask_q;
      iacq_pkg::OFF_CMP1: rdata_d = cmp_q[0];
      iacq_pkg::OFF_CMP2: rdata_d = cmp_q[1];
      iacq_pkg::OFF_CMP3: rdata_d = cmp_q[2];
      iacq_pkg::OFF_CMP4: rdata_d = cmp_q[3];
      default: rdata_d = iacq_pkg::RST_WORD;
    endcase
  end

  // Read data captured as the ack rises
  always_ff @(posedge clock) begin
    if (!resetn) begin
      rdata_q <= iacq_pkg::RST_WORD;
    end else if (bus_go && !wb_we_i) begin
      rdata_q <= rdata_d;
    end
  end

  // Event enable register
  always_ff @(posedge clock) begin
    if (!resetn) begin
      evt_en_q <= iacq_pkg::RST_NIB;
    end else if (wr_done && hit_off(wb_adr_i, iacq_pkg::OFF_CTRL0) && wb_sel_i[0]) begin
      evt_en_q <= wb_dat_i[3:0];
    end
  end

  // Mode, space selector and toggle enable register
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ctrl1_q <= iacq_pkg::RST_WORD;
    end else if (wr_done && hit_off(wb_adr_i, iacq_pkg::OFF_CTRL1)) begin
      ctrl1_q <= merge(ctrl1_q, wb_dat_i, wb_sel_i);
    end
  end

  // Interrupt mask register
  always_ff @(posedge clock) begin
    if (!resetn) begin
      mask_q <= iacq_pkg::RST_NIB;
    end else if (wr_done && hit_off(wb_adr_i, iacq_pkg::OFF_MASK) && wb_sel_i[0]) begin
      mask_q <= wb_dat_i[3:0];
    end
  end

  // Compare address registers, one per event
  for (genvar e = 0; e < iacq_pkg::NUM_EVT; e++) begin : g_cmp_reg
    always_ff @(posedge clock) begin
      if (!resetn) begin
        cmp_q[e] <= iacq_pkg::RST_WORD;
      end else if (wr_done && hit_off(wb_adr_i, iacq_pkg::OFF_CMP1 + 8'(e * 4))) begin
        cmp_q[e] <= merge(cmp_q[e], wb_dat_i, wb_sel_i);
      end
    end
    assign space_sel[e] = ctrl1_q[iacq_pkg::CTL1_SPACE_LSB + 2*e +: 2];
  end

  // Per-pair toggle enables from the control word
  assign tgl_en[0] = ctrl1_q[iacq_pkg::CTL1_TGL_A_BIT];
  assign tgl_en[1] = ctrl1_q[iacq_pkg::CTL1_TGL_B_BIT];

  // Pair configuration and comparators
  for (genvar p = 0; p < iacq_pkg::NUM_PAIR; p++) begin : g_pair
    localparam int unsigned MLSB = (p == 0) ? iacq_pkg::CTL1_MODE_A_LSB : iacq_pkg::CTL1_MODE_B_LSB;
    assign pair_cfg[p].mode = iacq_pkg::iacq_mode_t'(ctrl1_q[MLSB +: 2]);
    assign pair_cfg[p].tgl_en = tgl_en[p];
    assign pair_cfg[p].tgl_st = tgl_st_q[p];

    iacq_pair_cmp #(
      .AW(AW)
    ) u_cmp (
      .addr(insn.addr),
      .lo(cmp_q[2*p]),
      .hi(cmp_q[2*p+1]),
      .cfg(pair_cfg[p]),
      .match_lo(match[2*p]),
      .match_hi(match[2*p+1])
    );

    // Either event of the pair counts as a pair event
    assign pair_evt[p] = hit[2*p] | hit[2*p+1];
  end

  // Qualification of each event with the space flag of the same instruction
  for (genvar e = 0; e < iacq_pkg::NUM_EVT; e++) begin : g_evt
    iacq_event_qual u_qual (
      .valid(insn.valid),
      .enable(evt_en_q[e]),
      .space_sel(space_sel[e]),
      .space_flag(insn.space),
      .match(match[e]),
      .hit(hit[e])
    );
  end

  // Sticky event status; a read clears, a new event wins over the clear
  always_ff @(posedge clock) begin
    if (!resetn) begin
      evt_st_q <= iacq_pkg::RST_NIB;
    end else if (rd_done && hit_off(wb_adr_i, iacq_pkg::OFF_STATUS)) begin
      // Clear only what the read returned; a bit set after the data was captured survives
      evt_st_q <= (evt_st_q & ~rdata_q[3:0]) | hit;
    end else begin
      evt_st_q <= evt_st_q | hit;
    end
  end

  // Toggle status: flips on a pair event while the pair's toggle enable is set, else software may load it
  for (genvar p = 0; p < iacq_pkg::NUM_PAIR; p++) begin : g_tgl
    always_ff @(posedge clock) begin
      if (!resetn) begin
        tgl_st_q[p] <= 1'b0;
      end else if (pair_evt[p] && tgl_en[p]) begin
        tgl_st_q[p] <= ~tgl_st_q[p];
      end else if (wr_done && hit_off(wb_adr_i, iacq_pkg::OFF_STATUS) && wb_sel_i[0]) begin
        tgl_st_q[p] <= wb_dat_i[iacq_pkg::STAT_TS_LSB + p];
      end
    end
  end

  // One-cycle event pulses toward the core
  always_ff @(posedge clock) begin
    if (!resetn) begin
      hit_q <= iacq_pkg::RST_NIB;
    end else begin
      hit_q <= hit;
    end
  end

  assign cmp_hit = hit_q;
  assign pair_toggle_status = tgl_st_q;

  // Level interrupt while any unmasked status bit stands
  assign irq = |(evt_st_q & mask_q);

endmodule : iacq_top
`default_nettype wire

/* File: testbench/iacq_pipe_model.sv */
// Pipeline stand-in: presents one attempted instruction per request.
// Assumes requests are driven just after the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module iacq_pipe_model (
  input wire logic clock,
  input wire logic req,
  input wire logic req_space,
  input wire logic [31:0] req_addr,
  output var iacq_pkg::iacq_insn_t insn
);
  initial insn = '0;
  // Valid for one cycle; idle fields inverted each cycle, so stale values come back every second idle cycle
  always @(posedge clock) begin
    insn.valid <= req;
    insn.space <= req ? req_space : ~insn.space;
    insn.addr <= req ? req_addr : ~insn.addr;
  end
endmodule : iacq_pipe_model
`default_nettype wire

/* File: testbench/iacq_top_chk.sv */
// Checker for the qualifier: bus handshake, hit cause, toggle and irq causes.
// Assumes it is bound to iacq_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module iacq_top_chk (
  input wire logic clock,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire iacq_pkg::iacq_insn_t insn,
  input wire logic [3:0] cmp_hit,
  input wire logic [1:0] pair_toggle_status,
  input wire logic irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // Request present on the bus
  wire logic req = wb_cyc_i && wb_stb_i;
  AST_ACK_NEXT: assert property (req && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(req))
    else $error("ack without request");
  AST_HIT_CAUSE: assert property (|cmp_hit |-> $past(insn.valid))
    else $error("hit without instruction");
  AST_TGL_A: assert property ($past(resetn) && $changed(pair_toggle_status[0])
    && !$past(req && wb_we_i) |-> |cmp_hit[1:0])
    else $error("pair a toggle without event");
  AST_TGL_B: assert property ($past(resetn) && $changed(pair_toggle_status[1])
    && !$past(req && wb_we_i) |-> |cmp_hit[3:2])
    else $error("pair b toggle without event");
  AST_IRQ_RISE: assert property ($rose(irq) |-> |cmp_hit || $past(req && wb_we_i))
    else $error("irq rose without cause");
  AST_IRQ_FALL: assert property ($past(resetn) && $fell(irq) |-> $past(wb_ack_o))
    else $error("irq fell without access");
  AST_RDATA_HOLD: assert property ($past(resetn) && $changed(wb_dat_o) |-> $past(req && !wb_we_i))
    else $error("read data moved");
  // Main scenarios reached
  cover property (|cmp_hit);
  cover property ($changed(pair_toggle_status[0]));
  cover property ($rose(irq));
endmodule : iacq_top_chk
bind iacq_top iacq_top_chk iacq_top_chk_i (.clock, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .insn, .cmp_hit, .pair_toggle_status, .irq);
`default_nettype wire

/* File: testbench/test_iacq_top.sv */
// Self-checking bench for the instruction address compare qualifier.
// Assumes package, design, pipeline model and checker compiled before it.
`timescale 1ns/1ps
`default_nettype none
module test_iacq_top;
  typedef struct packed {logic [15:0] c1; logic [11:0] a; logic s; logic [3:0] h;} iacq_row_t;
  logic clock = 1'h0;
  logic resetn = 1'h0;
  logic cyc, stb, we, ack, req, rs, irq;
  logic [7:0] adr;
  logic [3:0] sel, hit;
  logic [31:0] wdat, rdat, ra, q;
  logic [1:0] pts;
  iacq_pkg::iacq_insn_t insn;
  int miscompares = 0;
  int checks_done = 0;
  // Control word, address, space flag, expected hits
  iacq_row_t rows [15] = '{'{16'h0002, 12'h100, 1'h0, 4'h3}, '{16'h0002, 12'h200, 1'h0, 4'h0},
    '{16'h0003, 12'h200, 1'h0, 4'h3}, '{16'h0003, 12'h0FF, 1'h0, 4'h3}, '{16'h0003, 12'h150, 1'h1, 4'h0},
    '{16'h0000, 12'h300, 1'h0, 4'h4}, '{16'h0000, 12'h400, 1'h1, 4'h8}, '{16'h00A0, 12'h100, 1'h1, 4'h0},
    '{16'h00A0, 12'h100, 1'h0, 4'h1}, '{16'h00F0, 12'h100, 1'h1, 4'h1}, '{16'h00F0, 12'h100, 1'h0, 4'h0},
    '{16'h0050, 12'h100, 1'h0, 4'h0}, '{16'h0F08, 12'h350, 1'h1, 4'hC}, '{16'h0F08, 12'h350, 1'h0, 4'h0},
    '{16'h0001, 12'h100, 1'h0, 4'h0}};
  iacq_top iacq_top_i (.clock(clock), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .insn(insn),
    .cmp_hit(hit), .pair_toggle_status(pts), .irq(irq));
  iacq_pipe_model iacq_pipe_model_i (.clock(clock), .req(req), .req_space(rs), .req_addr(ra), .insn(insn));
  always #10 clock = ~clock;
  // Compare and count
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  // One classic Wishbone cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clock);
    {cyc, stb, we, adr, sel, wdat} <= {2'h3, w, a, 4'hF, d};
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'h1 && n < 20);
    r = rdat;
    {cyc, stb} <= 2'h0;
    if (ack !== 1'h1) chk("ack", {31'h0, ack}, 32'h1);
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'h1, a, d, r);
  endtask : wr
  // One instruction through the pipeline model, settled result after
  task automatic send(input logic [31:0] a, input logic s);
    @(posedge clock);
    {req, rs, ra} <= {1'h1, s, a};
    @(posedge clock);
    req <= 1'h0;
    @(posedge clock);
    #1;
  endtask : send
  task automatic test_done;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done
  initial begin
    #400000;
    miscompares++;
    test_done;
  end
  initial begin
    {cyc, stb, we, adr, sel, wdat, req, rs, ra} = '0;
    repeat (8) @(posedge clock);
    resetn <= 1'h1;
    wb(1'h0, iacq_pkg::OFF_STATUS, 32'h0, q);
    chk("status", q, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    $display("test reset done");
    wr(iacq_pkg::OFF_CTRL0, 32'hF);
    for (int i = 0; i < 4; i++) wr(iacq_pkg::OFF_CMP1 + 8'(4 * i), 32'(256 * (i + 1)));
    foreach (rows[i]) begin
      wr(iacq_pkg::OFF_CTRL1, {16'h0, rows[i].c1});
      send({20'h0, rows[i].a}, rows[i].s);
      chk("hit", {28'h0, hit}, {28'h0, rows[i].h});
    end
    $display("test table done");
    wr(iacq_pkg::OFF_CTRL1, 32'h1002);
    send(32'h150, 1'h0);
    chk("hit", {28'h0, hit}, 32'h3);
    chk("toggle", {30'h0, pts}, 32'h1);
    send(32'h150, 1'h0);
    chk("hit", {28'h0, hit}, 32'h0);
    send(32'h50, 1'h0);
    chk("hit", {28'h0, hit}, 32'h3);
    chk("toggle", {30'h0, pts}, 32'h0);
    wr(iacq_pkg::OFF_STATUS, 32'h10);
    send(32'h150, 1'h0);
    chk("hit", {28'h0, hit}, 32'h0);
    chk("toggle", {30'h0, pts}, 32'h1);
    $display("test toggle done");
    wr(iacq_pkg::OFF_CTRL1, 32'h0);
    wb(1'h0, iacq_pkg::OFF_STATUS, 32'h0, q);
    wr(iacq_pkg::OFF_MASK, 32'h1);
    send(32'h300, 1'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    send(32'h100, 1'h0);
    chk("irq", {31'h0, irq}, 32'h1);
    wb(1'h0, iacq_pkg::OFF_STATUS, 32'h0, q);
    chk("status", q, 32'h15);
    wb(1'h0, iacq_pkg::OFF_STATUS, 32'h0, q);
    chk("status", q, 32'h10);
    chk("irq", {31'h0, irq}, 32'h0);
    wb(1'h0, 8'h40, 32'h0, q);
    chk("unmapped", q, 32'h0);
    $display("test irq done");
    // Reset in mid-run with a pending event, a set toggle bit and a mask
    send(32'h100, 1'h0);
    chk("irq", {31'h0, irq}, 32'h1);
    @(posedge clock);
    resetn <= 1'h0;
    repeat (2) @(posedge clock);
    resetn <= 1'h1;
    chk("toggle", {30'h0, pts}, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    chk("hit", {28'h0, hit}, 32'h0);
    wb(1'h0, iacq_pkg::OFF_STATUS, 32'h0, q);
    chk("status", q, 32'h0);
    wb(1'h0, iacq_pkg::OFF_MASK, 32'h0, q);
    chk("mask", q, 32'h0);
    $display("test midrun reset done");
    test_done;
  end
endmodule : test_iacq_top
`default_nettype wire
